// File: design/fbu_pkg.sv
// fbu_pkg: constants, register map, state encodings and carrier structs of the fractional baud uart
// assumes one 10 MHz core clock; every slower rate is an enable pulse derived from it
package fbu_pkg;
   localparam int unsigned CORE_CLK_HZ = 10_000_000;   // core clock rate, 100 ns period
   // register byte offsets on the plain register port
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_DIV     = 8'h04;
   localparam logic [7:0] OFS_TXDATA  = 8'h08;
   localparam logic [7:0] OFS_RXDATA  = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_IRQSTAT = 8'h14;
   localparam logic [7:0] OFS_IRQMASK = 8'h18;
   localparam logic [7:0] OFS_PINMUX  = 8'h1C;
   // reset values
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [15:0] DIV_RST    = 16'h0040;      // divisor 8.0 in eighths
   localparam logic [13:0] PINMUX_RST = 14'h0000;
   // field positions of the control word
   localparam int unsigned CTRL_REFSEL = 0;             // [1:0] 10 / 5 / 2.5 / 1.25 MHz
   localparam int unsigned CTRL_LEN8   = 2;             // 1: eight data bits, 0: seven
   localparam int unsigned CTRL_PAREN  = 3;             // parity enable
   localparam int unsigned CTRL_PARK   = 4;             // [5:4] parity kind
   localparam int unsigned CTRL_STOP2  = 6;             // 1: two stop bits
   // parity kinds
   localparam logic [1:0] PAR_ODD   = 2'h0;
   localparam logic [1:0] PAR_EVEN  = 2'h1;
   localparam logic [1:0] PAR_MARK  = 2'h2;
   localparam logic [1:0] PAR_SPACE = 2'h3;
   // interrupt status bit positions
   localparam int unsigned IRQ_RXRDY  = 0;
   localparam int unsigned IRQ_TXEMP  = 1;
   localparam int unsigned IRQ_PARERR = 2;
   localparam int unsigned IRQ_FRMERR = 3;
   localparam int unsigned IRQ_RXOVR  = 4;
   localparam int unsigned IRQ_TXOVF  = 5;
   localparam int unsigned IRQ_W      = 6;
   // pin mux: two bits per pin, rx pins 0..3 in [7:0], tx pins 0..2 in [13:8]
   localparam logic [1:0]  MUX_UART   = 2'h3;
   localparam int unsigned MUX_TXBASE = 8;
   // baud generation: oversampling by 8, accumulator in eighths of a reference tick
   localparam int unsigned FRAC_BITS  = 3;
   localparam logic [3:0]  OS_LAST    = 4'h7;          // ticks per bit minus one
   localparam logic [3:0]  OS_MID     = 4'h3;          // start-bit middle
   localparam logic [16:0] ACC_STEP   = 17'h0_0040;    // 8 ticks x 8 eighths per reference tick
   localparam logic [2:0]  FIFO_DEPTH = 3'h4;
   localparam logic [3:0]  LAST_BIT8  = 4'h7;
   localparam logic [3:0]  LAST_BIT7  = 4'h6;

   typedef enum logic [4:0] {
      TX_IDLE = 5'b0_0001, TX_START = 5'b0_0010, TX_DATA = 5'b0_0100,
      TX_PAR  = 5'b0_1000, TX_STOP  = 5'b1_0000
   } fbu_tx_e;
   typedef enum logic [4:0] {
      RX_IDLE = 5'b0_0001, RX_START = 5'b0_0010, RX_DATA = 5'b0_0100,
      RX_PAR  = 5'b0_1000, RX_STOP  = 5'b1_0000
   } fbu_rx_e;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fbu_req_s;

   // parity of a character of seven or eight bits
   function automatic logic fbu_parity(input logic [7:0] d, input logic len8, input logic [1:0] kind);
      logic x;
      x = ^(len8 ? d : {1'b0, d[6:0]});
      case (kind)
         PAR_ODD:  fbu_parity = ~x;
         PAR_EVEN: fbu_parity = x;
         PAR_MARK: fbu_parity = 1'b1;
         default:  fbu_parity = 1'b0;
      endcase
   endfunction : fbu_parity
endpackage : fbu_pkg

// File: design/fbu_uart.sv
// fbu_uart: two-wire asynchronous serial port with fractional baud divider, four-deep fifos each way
// assumes a 10 MHz core clock, a plain one-cycle register port and synchronous pin inputs
//
// Contract
// - rx taken from one of four pins, tx driven on three; pin active when its select is 3
// - software picks the reference clock: 10, 5, 2.5 or 1.25 MHz
// - divisor holds 13 integer bits and 3 fraction bits
// - symbol rate equals reference rate divided by the fractional divisor, divisors below 8.0 taken as 8.0
// - seven or eight data bits both ways
// - optional parity: odd, even, mark or space, sent and checked
// - one or two stop bits sent; receiver takes the same format
// - software reads the number of received characters waiting
// - receive and line errors shown in status bits
// - interrupt raised from sticky fifo events and error status
// - device is the terminal-equipment end: sends on tx, listens on rx
`timescale 1ns/1ps
module fbu_uart (
   input  wire logic             core_clk,     // 10 MHz core clock
   input  wire logic             rst_n,        // asynchronous reset, active low
   input  wire fbu_pkg::fbu_req_s bus_req,     // register port request
   output logic [31:0]           bus_rdata,    // read data, cycle after the read strobe
   input  wire logic [3:0]       rx_pins,      // candidate receive pins
   output logic [2:0]            tx_pin_out,   // candidate transmit pin levels
   output logic [2:0]            tx_pin_oe,    // transmit pin drive enables
   output logic                  irq           // level interrupt request
);
   typedef struct packed {
      logic [7:0]       ctrl;
      logic [15:0]      div;
      logic [13:0]      pinmux;
      logic [5:0]       irq_stat;
      logic [5:0]       irq_mask;
      logic [31:0]      rdata;
      logic [2:0]       pre;
      logic [16:0]      acc;
      logic [3:0][7:0]  txf;
      logic [1:0]       tx_wp;
      logic [1:0]       tx_rp;
      logic [2:0]       tx_cnt;
      logic [3:0][7:0]  rxf;
      logic [1:0]       rx_wp;
      logic [1:0]       rx_rp;
      logic [2:0]       rx_cnt;
      fbu_pkg::fbu_tx_e tx_st;
      logic [3:0]       tx_os;
      logic [3:0]       tx_bit;
      logic [7:0]       tx_sh;
      logic             tx_par;
      logic             tx_stop;
      logic             tx_line;
      fbu_pkg::fbu_rx_e rx_st;
      logic [3:0]       rx_os;
      logic [3:0]       rx_bit;
      logic [7:0]       rx_sh;
   } fbu_state_s;

   fbu_state_s  q;
   fbu_state_s  n;
   logic [1:0]  rst_sync;
   logic        rst_q;
   logic        ref_en;
   logic [2:0]  pre_mask;
   logic [16:0] acc_sum;
   logic [16:0] div_eff;
   logic        os_tick;
   logic        rxd;
   logic        len8;
   logic [3:0]  last_bit;
   logic        tx_pop;
   logic        tx_push;
   logic        rx_pop;
   logic        rx_push;
   logic [7:0]  rx_char;
   logic [5:0]  irq_set;
   logic        wr_ctrl;

   // reset release through two flops so that deassertion is clean against the clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_q = rst_sync[1];

   // reference clock as an enable pulse: every 1, 2, 4 or 8 core cycles
   assign pre_mask = (q.ctrl[fbu_pkg::CTRL_REFSEL +: 2] == 2'h0) ? 3'h0 :
                     (q.ctrl[fbu_pkg::CTRL_REFSEL +: 2] == 2'h1) ? 3'h1 :
                     (q.ctrl[fbu_pkg::CTRL_REFSEL +: 2] == 2'h2) ? 3'h3 : 3'h7;
   assign ref_en   = (q.pre & pre_mask) == 3'h0;

   // fractional accumulator in eighths: eight oversampling ticks per symbol of div/8 reference ticks
   // divisors below 8.0 are clamped, since at most one tick fits in a reference tick
   assign div_eff = (q.div < {1'b0, fbu_pkg::ACC_STEP[15:0]}) ? fbu_pkg::ACC_STEP : {1'b0, q.div};
   assign acc_sum = q.acc + fbu_pkg::ACC_STEP;
   assign os_tick = ref_en && (acc_sum >= div_eff);

   // receive pin select: lowest pin whose select reads 3, idle high if none
   always_comb begin
      rxd = 1'b1;
      for (int i = 3; i >= 0; i--) begin
         if (q.pinmux[2*i +: 2] == fbu_pkg::MUX_UART) begin
            rxd = rx_pins[i];
         end
      end
   end

   // every transmit pin level follows the line; drive is enabled only where selected
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         tx_pin_oe[i]  = q.pinmux[fbu_pkg::MUX_TXBASE + 2*i +: 2] == fbu_pkg::MUX_UART;
         tx_pin_out[i] = q.tx_line;
      end
   end

   assign len8     = q.ctrl[fbu_pkg::CTRL_LEN8];
   assign last_bit = len8 ? fbu_pkg::LAST_BIT8 : fbu_pkg::LAST_BIT7;
   assign rx_char  = len8 ? q.rx_sh : {1'b0, q.rx_sh[7:1]};
   assign wr_ctrl  = bus_req.wr && bus_req.addr == fbu_pkg::OFS_CTRL;
   assign tx_pop   = os_tick && q.tx_st == fbu_pkg::TX_IDLE && q.tx_cnt != 3'h0;
   assign tx_push  = bus_req.wr && bus_req.addr == fbu_pkg::OFS_TXDATA &&
                     (q.tx_cnt != fbu_pkg::FIFO_DEPTH || tx_pop);
   assign rx_pop   = bus_req.rd && bus_req.addr == fbu_pkg::OFS_RXDATA && q.rx_cnt != 3'h0;
   assign rx_push  = os_tick && q.rx_st == fbu_pkg::RX_STOP && q.rx_os == fbu_pkg::OS_LAST &&
                     (q.rx_cnt != fbu_pkg::FIFO_DEPTH || rx_pop);
   assign irq      = |(q.irq_stat & q.irq_mask);
   assign bus_rdata = q.rdata;

   // next state of the whole block
   always_comb begin
      n       = q;
      irq_set = 6'h00;
      n.pre   = q.pre + 3'h1;
      if (ref_en) begin
         n.acc = os_tick ? (acc_sum - div_eff) : acc_sum;
      end
      // register writes
      if (bus_req.wr) begin
         case (bus_req.addr)
            fbu_pkg::OFS_CTRL:    n.ctrl = bus_req.wdata[7:0];
            fbu_pkg::OFS_DIV:     n.div = bus_req.wdata[15:0];
            fbu_pkg::OFS_IRQMASK: n.irq_mask = bus_req.wdata[5:0];
            fbu_pkg::OFS_PINMUX:  n.pinmux = bus_req.wdata[13:0];
            default:              n.ctrl = q.ctrl;
         endcase
      end
      if (wr_ctrl) begin
         n.pre = 3'h0;   // restart the prescaler so a new rate starts cleanly
      end
      if (wr_ctrl || (bus_req.wr && bus_req.addr == fbu_pkg::OFS_DIV)) begin
         n.acc = 17'h0_0000;   // a smaller new divisor must not leave the accumulator above it
      end
      // read data from the state before this cycle's updates
      n.rdata = 32'h0000_0000;
      if (bus_req.rd) begin
         case (bus_req.addr)
            fbu_pkg::OFS_CTRL:    n.rdata = {24'h00_0000, q.ctrl};
            fbu_pkg::OFS_DIV:     n.rdata = {16'h0000, q.div};
            fbu_pkg::OFS_RXDATA:  n.rdata = {24'h00_0000, (q.rx_cnt != 3'h0) ? q.rxf[q.rx_rp] : 8'h00};
            fbu_pkg::OFS_STATUS:  n.rdata = {16'h0000, q.irq_stat, q.tx_st != fbu_pkg::TX_IDLE,
                                             q.tx_cnt, q.rx_cnt[2:0], 3'h0} >> 3;
            fbu_pkg::OFS_IRQSTAT: n.rdata = {26'h000_0000, q.irq_stat};
            fbu_pkg::OFS_IRQMASK: n.rdata = {26'h000_0000, q.irq_mask};
            fbu_pkg::OFS_PINMUX:  n.rdata = {18'h0_0000, q.pinmux};
            default:              n.rdata = 32'h0000_0000;
         endcase
      end
      // transmit fifo
      if (tx_push) begin
         n.txf[q.tx_wp] = bus_req.wdata[7:0];
         n.tx_wp        = q.tx_wp + 2'h1;
      end
      if (bus_req.wr && bus_req.addr == fbu_pkg::OFS_TXDATA && !tx_push) begin
         irq_set[fbu_pkg::IRQ_TXOVF] = 1'b1;
      end
      if (tx_pop) begin
         n.tx_rp = q.tx_rp + 2'h1;
         if (q.tx_cnt == 3'h1 && !tx_push) begin
            irq_set[fbu_pkg::IRQ_TXEMP] = 1'b1;
         end
      end
      n.tx_cnt = q.tx_cnt + {2'b00, tx_push} - {2'b00, tx_pop};
      // transmitter: each bit lasts eight oversampling ticks
      if (os_tick) begin
         n.tx_os = (q.tx_os == fbu_pkg::OS_LAST) ? 4'h0 : q.tx_os + 4'h1;
         case (q.tx_st)
            fbu_pkg::TX_IDLE: begin
               n.tx_line = 1'b1;
               n.tx_os   = 4'h0;
               if (tx_pop) begin
                  n.tx_sh   = q.txf[q.tx_rp];
                  n.tx_par  = fbu_pkg::fbu_parity(q.txf[q.tx_rp], len8, q.ctrl[fbu_pkg::CTRL_PARK +: 2]);
                  n.tx_line = 1'b0;
                  n.tx_st   = fbu_pkg::TX_START;
               end
            end
            fbu_pkg::TX_START: begin
               if (q.tx_os == fbu_pkg::OS_LAST) begin
                  n.tx_line = q.tx_sh[0];
                  n.tx_bit  = 4'h0;
                  n.tx_st   = fbu_pkg::TX_DATA;
               end
            end
            fbu_pkg::TX_DATA: begin
               if (q.tx_os == fbu_pkg::OS_LAST) begin
                  n.tx_sh  = {1'b0, q.tx_sh[7:1]};
                  n.tx_bit = q.tx_bit + 4'h1;
                  if (q.tx_bit == last_bit) begin
                     n.tx_stop = 1'b0;
                     if (q.ctrl[fbu_pkg::CTRL_PAREN]) begin
                        n.tx_line = q.tx_par;
                        n.tx_st   = fbu_pkg::TX_PAR;
                     end else begin
                        n.tx_line = 1'b1;
                        n.tx_st   = fbu_pkg::TX_STOP;
                     end
                  end else begin
                     n.tx_line = q.tx_sh[1];
                  end
               end
            end
            fbu_pkg::TX_PAR: begin
               if (q.tx_os == fbu_pkg::OS_LAST) begin
                  n.tx_line = 1'b1;
                  n.tx_st   = fbu_pkg::TX_STOP;
               end
            end
            fbu_pkg::TX_STOP: begin
               n.tx_line = 1'b1;
               if (q.tx_os == fbu_pkg::OS_LAST) begin
                  n.tx_stop = 1'b1;
                  if (q.tx_stop || !q.ctrl[fbu_pkg::CTRL_STOP2]) begin
                     n.tx_st = fbu_pkg::TX_IDLE;
                  end
               end
            end
            default: begin
               n.tx_st   = fbu_pkg::TX_IDLE;
               n.tx_line = 1'b1;
            end
         endcase
      end
      // receiver: start found, checked at its middle, then one sample per bit middle
      // only the first stop bit is checked, which lets the line resynchronise on the next start
      if (os_tick) begin
         n.rx_os = (q.rx_os == fbu_pkg::OS_LAST) ? 4'h0 : q.rx_os + 4'h1;
         case (q.rx_st)
            fbu_pkg::RX_IDLE: begin
               n.rx_os = 4'h0;
               if (!rxd) begin
                  n.rx_st = fbu_pkg::RX_START;
               end
            end
            fbu_pkg::RX_START: begin
               if (q.rx_os == fbu_pkg::OS_MID) begin
                  n.rx_os  = 4'h0;
                  n.rx_bit = 4'h0;
                  n.rx_st  = rxd ? fbu_pkg::RX_IDLE : fbu_pkg::RX_DATA;
               end
            end
            fbu_pkg::RX_DATA: begin
               if (q.rx_os == fbu_pkg::OS_LAST) begin
                  n.rx_sh  = {rxd, q.rx_sh[7:1]};
                  n.rx_bit = q.rx_bit + 4'h1;
                  if (q.rx_bit == last_bit) begin
                     n.rx_st = q.ctrl[fbu_pkg::CTRL_PAREN] ? fbu_pkg::RX_PAR : fbu_pkg::RX_STOP;
                  end
               end
            end
            fbu_pkg::RX_PAR: begin
               if (q.rx_os == fbu_pkg::OS_LAST) begin
                  if (rxd != fbu_pkg::fbu_parity(rx_char, len8, q.ctrl[fbu_pkg::CTRL_PARK +: 2])) begin
                     irq_set[fbu_pkg::IRQ_PARERR] = 1'b1;
                  end
                  n.rx_st = fbu_pkg::RX_STOP;
               end
            end
            fbu_pkg::RX_STOP: begin
               if (q.rx_os == fbu_pkg::OS_LAST) begin
                  irq_set[fbu_pkg::IRQ_FRMERR] = !rxd;
                  irq_set[fbu_pkg::IRQ_RXOVR]  = !rx_push;
                  irq_set[fbu_pkg::IRQ_RXRDY]  = rx_push;
                  n.rx_st = fbu_pkg::RX_IDLE;
               end
            end
            default: n.rx_st = fbu_pkg::RX_IDLE;
         endcase
      end
      // receive fifo
      if (rx_push) begin
         n.rxf[q.rx_wp] = rx_char;
         n.rx_wp        = q.rx_wp + 2'h1;
      end
      if (rx_pop) begin
         n.rx_rp = q.rx_rp + 2'h1;
      end
      n.rx_cnt = q.rx_cnt + {2'b00, rx_push} - {2'b00, rx_pop};
      // sticky status: a new event wins over a write-one-to-clear in the same cycle
      n.irq_stat = q.irq_stat | irq_set;
      if (bus_req.wr && bus_req.addr == fbu_pkg::OFS_IRQSTAT) begin
         n.irq_stat = (q.irq_stat & ~bus_req.wdata[5:0]) | irq_set;
      end
   end

   // the one state register
   always_ff @(posedge core_clk or negedge rst_q) begin
      if (!rst_q) begin
         q          <= '0;
         q.ctrl     <= fbu_pkg::CTRL_RST;
         q.div      <= fbu_pkg::DIV_RST;
         q.pinmux   <= fbu_pkg::PINMUX_RST;
         q.tx_st    <= fbu_pkg::TX_IDLE;
         q.rx_st    <= fbu_pkg::RX_IDLE;
         q.tx_line  <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_q);

   property p_tx_mux;
      (q.pinmux[9:8] != fbu_pkg::MUX_UART) |-> !tx_pin_oe[0];
   endproperty
   a_tx_mux: assert property (p_tx_mux) else $error("tx pin driven without uart select");

   property p_ref_half;
      (q.ctrl[1:0] == 2'h1 && ref_en && !wr_ctrl) |=> !ref_en ##1 ref_en;
   endproperty
   a_ref_half: assert property (p_ref_half) else $error("5 MHz reference enable not every other cycle");

   property p_acc_bound;
      q.acc < div_eff || wr_ctrl || $changed(q.div);
   endproperty
   a_acc_bound: assert property (p_acc_bound) else $error("baud accumulator above divisor");

   property p_tick_rate;
      (q.div == 16'h0040 && q.ctrl[1:0] == 2'h0 && !wr_ctrl) |-> os_tick;
   endproperty
   a_tick_rate: assert property (p_tick_rate) else $error("divisor 8.0 at 10 MHz must tick every cycle");

   property p_start_low;
      $rose(q.tx_st == fbu_pkg::TX_START) |-> !q.tx_line;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");

   property p_par_mark;
      (q.tx_st == fbu_pkg::TX_PAR && q.ctrl[5:4] == fbu_pkg::PAR_MARK) |-> q.tx_line;
   endproperty
   a_par_mark: assert property (p_par_mark) else $error("mark parity bit not high");

   property p_stop_high;
      (q.tx_st == fbu_pkg::TX_STOP || q.tx_st == fbu_pkg::TX_IDLE) |-> q.tx_line;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop or idle line not high");

   property p_fifo_bound;
      q.rx_cnt <= fbu_pkg::FIFO_DEPTH && q.tx_cnt <= fbu_pkg::FIFO_DEPTH;
   endproperty
   a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count beyond four");

   property p_frame_err;
      (os_tick && q.rx_st == fbu_pkg::RX_STOP && q.rx_os == fbu_pkg::OS_LAST && !rxd)
         |=> q.irq_stat[fbu_pkg::IRQ_FRMERR];
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("low stop bit not flagged");

   property p_count_read;
      (bus_req.rd && bus_req.addr == fbu_pkg::OFS_STATUS) |=> bus_rdata[2:0] == $past(q.rx_cnt);
   endproperty
   a_count_read: assert property (p_count_read) else $error("status count differs from fifo");

   property p_irq_set;
      (|(irq_set & q.irq_mask) && !(bus_req.wr && bus_req.addr == fbu_pkg::OFS_IRQMASK)) |=> irq;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("masked-in event gave no interrupt");

   c_tx_frame: cover property ($fell(q.tx_st == fbu_pkg::TX_STOP));
   c_rx_push:  cover property (rx_push);
   c_rx_full:  cover property (q.rx_cnt == fbu_pkg::FIFO_DEPTH);
   c_irq:      cover property ($rose(irq));
endmodule : fbu_uart

// File: dv/fbu_term_model.sv
// fbu_term_model: behavioural serial terminal at the far end of the uart link
// assumes the bench sets bit_ns and the frame format before every transfer
`timescale 1ns/1ps
module fbu_term_model (
   input  wire logic       core_clk,  // bench clock, times the result pulse only
   input  wire logic       line_in,   // device transmit line, pulled high when undriven
   output logic            line_out,  // device receive line, idles high
   output logic            got_v,     // one-cycle pulse per decoded frame
   output logic [9:0]      got_w      // {stop, parity, data}
);
   realtime    bit_ns = 800.0;
   logic       len8   = 1'b1;
   logic       par_en = 1'b0;
   logic       stop2  = 1'b0;
   logic [7:0] d;
   logic       p;
   logic       s;

   initial line_out = 1'b1;

   // decoder samples every bit at its middle, both stops when two are set
   initial begin
      got_v = 1'b0;
      got_w = '0;
      forever begin
         @(negedge line_in);
         #(bit_ns / 2);
         d = 8'h00;
         p = 1'b0;
         for (int i = 0; i < (len8 ? 8 : 7); i++) begin
            #(bit_ns);
            d[i] = line_in;
         end
         if (par_en) begin
            #(bit_ns);
            p = line_in;
         end
         #(bit_ns);
         s = line_in;
         if (stop2) begin
            #(bit_ns);
            s = s & line_in;
         end
         @(posedge core_clk);
         got_w <= {s, p, d};
         got_v <= 1'b1;
         @(posedge core_clk);
         got_v <= 1'b0;
      end
   end

   // encoder; a low stop is let go after three quarters of a bit so that its middle still reads low
   task automatic send(input logic [7:0] c, input logic pb, input logic stop_hi);
      #37;
      line_out = 1'b0;
      #(bit_ns);
      for (int i = 0; i < (len8 ? 8 : 7); i++) begin
         line_out = c[i];
         #(bit_ns);
      end
      if (par_en) begin
         line_out = pb;
         #(bit_ns);
      end
      line_out = stop_hi;
      #(bit_ns * 0.75);
      line_out = 1'b1;
      #(bit_ns * (stop2 ? 1.25 : 0.25));
   endtask : send
endmodule : fbu_term_model

// File: dv/fbu_uart_tb_top.sv
// fbu_uart_tb_top: self-checking bench of the fractional baud uart
// assumes the terminal model on rx pin 2 and tx pin 1, both ends set to one format
`timescale 1ns/1ps
module fbu_uart_tb_top;
   logic              core_clk;
   logic              rst_n;
   logic              irq;
   fbu_pkg::fbu_req_s bus_req;
   logic [31:0]       bus_rdata;
   logic [3:0]        rx_pins;
   logic [2:0]        tx_pin_out;
   logic [2:0]        tx_pin_oe;
   logic              m_rx;
   logic              got_v;
   logic [9:0]        got_w;
   logic              rd_d = 1'b0;
   logic [63:0]       re;
   logic [63:0]       rdq[$];
   logic [9:0]        txq[$];
   int                n_mismatch = 0;
   int                tests_run = 0;
   logic [7:0]        c;
   logic [7:0]        ctl;
   logic [23:0]       cfgs[5] = '{24'h04_0040, 24'h48_0064, 24'h1D_0040, 24'h2E_0040, 24'h3B_0040};

   fbu_uart dut_u (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .rx_pins(rx_pins), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .irq(irq));
   fbu_term_model term_u (.core_clk(core_clk), .line_in(tx_pin_oe[1] ? tx_pin_out[1] : 1'b1),
      .line_out(m_rx), .got_v(got_v), .got_w(got_w));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // unselected pins carry noise so a wrong pin choice shows up
   always @(posedge core_clk) rx_pins <= {1'($urandom), m_rx, 2'($urandom)};

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   // read data stands only in the cycle after the strobe
   always @(posedge core_clk) begin
      rd_d <= bus_req.rd;
      if (rd_d === 1'b1 && rdq.size() > 0) begin
         re = rdq.pop_front();
         cmp("rdata", re[63:32], bus_rdata & re[31:0]);
      end
      if (got_v === 1'b1) cmp("frame", txq.size() ? 32'(txq.pop_front()) : '1, 32'(got_w));
   end

   task automatic acc(input logic [7:0] a, input logic [31:0] wd, input logic w);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: wd, wr: w, rd: ~w};
      @(posedge core_clk);
      bus_req <= '0;
   endtask : acc

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rdq.push_back({e, m});
      acc(a, 32'h0, 1'b0);
   endtask : rd

   function automatic logic par(input logic [7:0] v, input logic [7:0] k);
      logic x;
      x = ^(k[2] ? v : {1'b0, v[6:0]});
      case (k[5:4])
         2'h0: par = ~x;
         2'h1: par = x;
         2'h2: par = 1'b1;
         default: par = 1'b0;
      endcase
   endfunction : par

   // both ends get one format; divisor kept at 8.0 or more
   task automatic cfg(input logic [7:0] k, input logic [15:0] dv);
      acc(fbu_pkg::OFS_CTRL, 32'(k), 1'b1);
      acc(fbu_pkg::OFS_DIV, 32'(dv), 1'b1);
      term_u.bit_ns = 100.0 * real'(1 << k[1:0]) * real'(dv) / 8.0;
      term_u.len8 = k[2];
      term_u.par_en = k[3];
      term_u.stop2 = k[6];
   endtask : cfg

   task automatic tx(input logic [7:0] v, input logic [7:0] k);
      txq.push_back({1'b1, k[3] & par(v, k), k[2] ? v : {1'b0, v[6:0]}});
      acc(fbu_pkg::OFS_TXDATA, 32'(v), 1'b1);
   endtask : tx

   // the wait is bounded, then the last stop bits are let out before any change
   task automatic drain();
      for (int i = 0; i < 8000 && txq.size() > 0; i++) @(posedge core_clk);
      cmp("tx drained", 32'h0, 32'(txq.size()));
      #(2 * term_u.bit_ns);
   endtask : drain

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   initial begin
      repeat (60000) @(posedge core_clk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      void'($urandom(32'h21d27373));
      rst_n = 1'b0;
      bus_req = '0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      cmp("oe at reset", 32'h0, 32'(tx_pin_oe));
      rd(fbu_pkg::OFS_DIV, 32'(fbu_pkg::DIV_RST), 32'h0000_FFFF);
      rd(8'h20, 32'h0, 32'hFFFF_FFFF);
      acc(fbu_pkg::OFS_PINMUX, 32'h0000_0C30, 1'b1);
      rd(fbu_pkg::OFS_PINMUX, 32'h0000_0C30, 32'h0000_3FFF);
      cmp("tx oe", 32'h2, 32'(tx_pin_oe));
      // every length, parity kind, stop count and reference rate, both ways
      foreach (cfgs[k]) begin
         ctl = cfgs[k][23:16];
         cfg(ctl, cfgs[k][15:0]);
         tx(8'($urandom), ctl);
         drain();
         c = 8'($urandom);
         term_u.send(c, par(c, ctl), 1'b1);
         rd(fbu_pkg::OFS_RXDATA, 32'(ctl[2] ? c : {1'b0, c[6:0]}), 32'h0000_00FF);
         rd(fbu_pkg::OFS_IRQSTAT, 32'h3, 32'h0000_003F);
         cmp("irq masked", 32'h0, 32'(irq));
         acc(fbu_pkg::OFS_IRQSTAT, 32'h0000_003F, 1'b1);
      end
      // parity and framing errors, each raised, seen on irq and cleared
      cfg(8'h0C, 16'h0040);
      acc(fbu_pkg::OFS_IRQMASK, 32'h0000_000C, 1'b1);
      c = 8'($urandom);
      term_u.send(c, ~par(c, 8'h0C), 1'b1);
      rd(fbu_pkg::OFS_IRQSTAT, 32'h4, 32'h0000_000C);
      cmp("irq parity", 32'h1, 32'(irq));
      acc(fbu_pkg::OFS_IRQSTAT, 32'h4, 1'b1);
      rd(fbu_pkg::OFS_IRQSTAT, 32'h0, 32'h0000_000C);
      cmp("irq cleared", 32'h0, 32'(irq));
      term_u.send(c, par(c, 8'h0C), 1'b0);
      rd(fbu_pkg::OFS_IRQSTAT, 32'h8, 32'h0000_000C);
      cmp("irq framing", 32'h1, 32'(irq));
      rd(fbu_pkg::OFS_RXDATA, 32'(c), 32'h0000_00FF);
      rd(fbu_pkg::OFS_RXDATA, 32'(c), 32'h0000_00FF);
      acc(fbu_pkg::OFS_IRQSTAT, 32'h0000_003F, 1'b1);
      // five characters into a four-deep receive fifo
      cfg(8'h04, 16'h0040);
      for (int i = 0; i < 5; i++) term_u.send(8'hA0 + 8'(i), 1'b0, 1'b1);
      rd(fbu_pkg::OFS_STATUS, 32'h0000_0804, 32'h0000_0807);
      for (int i = 0; i < 5; i++) rd(fbu_pkg::OFS_RXDATA, i < 4 ? 32'hA0 + i : 32'h0, 32'h0000_00FF);
      rd(fbu_pkg::OFS_STATUS, 32'h0, 32'h0000_0007);
      // seven writes: one leaves at once, four wait, two are refused
      for (int i = 0; i < 7; i++) begin
         c = 8'($urandom);
         if (i < 5)
            tx(c, 8'h04);
         else
            acc(fbu_pkg::OFS_TXDATA, 32'(c), 1'b1);
      end
      drain();
      rd(fbu_pkg::OFS_IRQSTAT, 32'h0000_0022, 32'h0000_0022);
      cmp("irq unmasked off", 32'h0, 32'(irq));
      acc(fbu_pkg::OFS_IRQMASK, 32'h0000_0020, 1'b1);
      rd(fbu_pkg::OFS_IRQMASK, 32'h0000_0020, 32'h0000_003F);
      cmp("irq overflow", 32'h1, 32'(irq));
      complete_run();
   end
endmodule : fbu_uart_tb_top
